// file: rfsw_slave.sv
// rfsw_slave.sv: switch end of the link, decodes frames into registers.
// Assumes the master makes the link clock and launches data on its
// falling edge, so data is stable at the rising edge used here.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Frames open with start then slave address
// - Compact write carries seven bits to path
// - Full write: address, parity, data, parity
// - Read: park, eight bits plus parity, park
// - Driver parks line low before releasing, except the master ahead of a read
// - Path register at zero, resets to isolation
// - Power register bit seven selects low power
// - Low five path bits decode the throws
// - Startup bit returns all registers to defaults
// - Clear trigger mask routes writes via shadow
module rfsw_slave #(
	parameter logic [3:0] SLAVE_ID = rfsw_pkg::SLAVE_ID_DEFAULT
) (
	rfsw_link_if.dev link,
	input wire logic reset,
	output logic [9:0] throw_on,
	output logic isolated,
	output logic low_power
);

	typedef enum logic [6:0] {
		S_IDLE = 7'h01,
		S_START = 7'h02,
		S_CMD = 7'h04,
		S_WDATA = 7'h08,
		S_PARK = 7'h10,
		S_RDATA = 7'h20,
		S_RPARK = 7'h40
	} rfsw_dev_state_t;

	// One-hot throw select; all zero is the isolation state
	function automatic logic [9:0] throw_decode(input logic [7:0] p);
		logic [9:0] t;
		t = 10'h000;
		if (!p[4]) begin
			case (p[3:0])
				4'h2: t = 10'h001;
				4'ha: t = 10'h002;
				4'he: t = 10'h004;
				4'hb: t = 10'h008;
				4'h1: t = 10'h010;
				4'h9: t = 10'h020;
				4'h6: t = 10'h040;
				4'h4: t = 10'h080;
				4'hc: t = 10'h100;
				4'h8: t = 10'h200;
				default: t = 10'h000;
			endcase
		end
		return t;
	endfunction

	rfsw_dev_state_t state_reg;
	rfsw_dev_state_t state_next;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [11:0] sr_reg;
	logic [11:0] sr_next;
	logic [11:0] cmd_reg;
	logic cmd_ok_reg;
	logic out_reg;
	logic out_next;
	logic oe_reg;
	logic oe_next;
	logic [7:0] path_reg;
	logic [7:0] shadow_reg;
	logic lowp_reg;
	logic [2:0] mask_reg;

	// Command frame checks, valid while the parity bit is on the line
	wire logic bit_in = link.sdata;
	wire logic cmd_end = (state_reg == S_CMD) &&
		(cnt_reg == rfsw_pkg::CMD_LAST);
	wire logic cmd_par_ok = bit_in == rfsw_pkg::odd_par(sr_reg);
	wire logic cmd_hit = cmd_par_ok &&
		(sr_reg[rfsw_pkg::CMD_SA_MSB:rfsw_pkg::CMD_SA_LSB] == SLAVE_ID);
	wire logic cmd_reg0 = sr_reg[rfsw_pkg::CMD_REG0_BIT];
	wire logic [1:0] cmd_op =
		sr_reg[rfsw_pkg::CMD_OP_MSB:rfsw_pkg::CMD_OP_LSB];
	wire logic [1:0] held_op =
		cmd_reg[rfsw_pkg::CMD_OP_MSB:rfsw_pkg::CMD_OP_LSB];
	wire logic [4:0] held_addr = cmd_reg[rfsw_pkg::CMD_ADDR_MSB:0];

	// Data frame check, valid while its parity bit is on the line
	wire logic data_end = (state_reg == S_WDATA) &&
		(cnt_reg == rfsw_pkg::DATA_LAST);
	wire logic data_par_ok =
		bit_in == rfsw_pkg::odd_par({4'h0, sr_reg[7:0]});

	// Write strobes; a failed parity or foreign address writes nothing
	wire logic wr_reg0 = cmd_end && cmd_hit && cmd_reg0;
	wire logic wr_full = data_end && cmd_ok_reg && data_par_ok;
	wire logic wr_en = wr_reg0 | wr_full;
	wire logic [4:0] wr_addr = wr_reg0 ? rfsw_pkg::ADDR_PATH : held_addr;
	wire logic [7:0] wr_data = wr_reg0 ? {1'b0, sr_reg[6:0]} :
		sr_reg[7:0];
	wire logic wr_path = wr_en && (wr_addr == rfsw_pkg::ADDR_PATH);
	wire logic wr_pwr = wr_en && (wr_addr == rfsw_pkg::ADDR_PWR);

	// Startup bit wins over every other field of the same write
	wire logic startup = wr_pwr && wr_data[rfsw_pkg::PWR_START_BIT];
	wire logic trig0 = wr_pwr && !startup &&
		wr_data[rfsw_pkg::PWR_TRIG0_BIT];
	wire logic mask0 = mask_reg[0];

	// Register next values
	wire logic [7:0] shadow_next = startup ? rfsw_pkg::PATH_RESET :
		(wr_path ? wr_data : shadow_reg);
	wire logic [7:0] path_next = startup ? rfsw_pkg::PATH_RESET :
		(wr_path && mask0) ? wr_data :
		trig0 ? shadow_reg : path_reg;
	wire logic lowp_next = startup ?
		rfsw_pkg::PWR_RESET[rfsw_pkg::PWR_LOWP_BIT] :
		wr_pwr ? wr_data[rfsw_pkg::PWR_LOWP_BIT] : lowp_reg;
	wire logic [2:0] mask_next = startup ?
		rfsw_pkg::PWR_RESET[rfsw_pkg::PWR_MASK_MSB:rfsw_pkg::PWR_MASK_LSB] :
		wr_pwr ? wr_data[rfsw_pkg::PWR_MASK_MSB:rfsw_pkg::PWR_MASK_LSB] :
		mask_reg;
	wire logic [9:0] throw_next = throw_decode(path_next);

	// Read data; triggers and startup bit read back as zero
	wire logic [7:0] pwr_view = {lowp_reg, 1'b0, mask_reg, 3'h0};
	wire logic [7:0] rd_data =
		(held_addr == rfsw_pkg::ADDR_PATH) ? path_reg :
		(held_addr == rfsw_pkg::ADDR_PWR) ? pwr_view : 8'h00;
	wire logic rd_go = cmd_ok_reg && !cmd_reg[rfsw_pkg::CMD_REG0_BIT] &&
		(held_op == rfsw_pkg::OP_READ);

	// Frame sequencer; the clock stops after the last park cycle, so
	// every frame must land back in idle on its own final edge
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sr_next = sr_reg;
		out_next = out_reg;
		oe_next = oe_reg;
		unique case (state_reg)
			S_IDLE: begin
				if (bit_in) begin
					state_next = S_START;
				end
			end
			S_START: begin
				if (!bit_in) begin
					state_next = S_CMD;
					cnt_next = 4'h0;
				end
			end
			S_CMD: begin
				cnt_next = cnt_reg + 4'h1;
				sr_next = {sr_reg[10:0], bit_in};
				if (cmd_end) begin
					cnt_next = 4'h0;
					sr_next = sr_reg;
					if (cmd_reg0 || (cmd_op == rfsw_pkg::OP_READ)) begin
						state_next = S_PARK;
					end else if (cmd_op == rfsw_pkg::OP_WRITE) begin
						state_next = S_WDATA;
					end else begin
						state_next = S_IDLE;
					end
				end
			end
			S_WDATA: begin
				cnt_next = cnt_reg + 4'h1;
				sr_next = {sr_reg[10:0], bit_in};
				if (data_end) begin
					sr_next = sr_reg;
					state_next = S_PARK;
				end
			end
			S_PARK: begin
				// Master has released the line without parking it; take it over for a read
				state_next = S_IDLE;
				if (rd_go) begin
					state_next = S_RDATA;
					cnt_next = 4'h0;
					oe_next = 1'b1;
					out_next = rd_data[7];
					sr_next = {rd_data[6:0],
						rfsw_pkg::odd_par({4'h0, rd_data}), 4'h0};
				end
			end
			S_RDATA: begin
				cnt_next = cnt_reg + 4'h1;
				out_next = sr_reg[11];
				sr_next = {sr_reg[10:0], 1'b0};
				if (cnt_reg == rfsw_pkg::DATA_LAST) begin
					out_next = 1'b0;
					state_next = S_RPARK;
				end
			end
			S_RPARK: begin
				// Line held low one bit before it is let go
				oe_next = 1'b0;
				state_next = S_IDLE;
			end
		endcase
	end

	// Sequencer and line driver registers
	always_ff @(posedge link.sclk or posedge reset) begin
		if (reset) begin
			state_reg <= S_IDLE;
			cnt_reg <= 4'h0;
			sr_reg <= 12'h000;
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sr_reg <= sr_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
		end
	end

	// Command capture for the data and read phases
	always_ff @(posedge link.sclk or posedge reset) begin
		if (reset) begin
			cmd_reg <= 12'h000;
			cmd_ok_reg <= 1'b0;
		end else if (cmd_end) begin
			cmd_reg <= sr_reg;
			cmd_ok_reg <= cmd_hit;
		end
	end

	// Device registers and decoded switch outputs
	always_ff @(posedge link.sclk or posedge reset) begin
		if (reset) begin
			path_reg <= rfsw_pkg::PATH_RESET;
			shadow_reg <= rfsw_pkg::PATH_RESET;
			lowp_reg <= 1'b0;
			mask_reg <= 3'h0;
			throw_on <= 10'h000;
			isolated <= 1'b1;
		end else begin
			path_reg <= path_next;
			shadow_reg <= shadow_next;
			lowp_reg <= lowp_next;
			mask_reg <= mask_next;
			throw_on <= throw_next;
			isolated <= ~|throw_next;
		end
	end

	// Outputs straight from registers
	assign low_power = lowp_reg;
	assign link.dev_sdata_out = out_reg;
	assign link.dev_sdata_oe = oe_reg;

endmodule // rfsw_slave
`default_nettype wire

// file: rfsw_pkg.sv
// rfsw_pkg.sv: shared constants and helpers for the RF switch serial link.
// Assumes both ends and the master's register bus compile against it.
`default_nettype none
package rfsw_pkg;

	// Command word layout, twelve bits, address nibble on top
	localparam int CMD_BITS = 12;
	localparam int CMD_SA_MSB = 11;
	localparam int CMD_SA_LSB = 8;
	localparam int CMD_REG0_BIT = 7;
	localparam int CMD_OP_MSB = 6;
	localparam int CMD_OP_LSB = 5;
	localparam int CMD_ADDR_MSB = 4;
	localparam logic [1:0] OP_WRITE = 2'h2;
	localparam logic [1:0] OP_READ = 2'h3;
	localparam logic [3:0] CMD_LAST = 4'hc;
	localparam logic [3:0] DATA_LAST = 4'h8;

	// Device register map and reset values
	localparam logic [4:0] ADDR_PATH = 5'h00;
	localparam logic [4:0] ADDR_PWR = 5'h1c;
	localparam logic [7:0] PATH_RESET = 8'h00;
	localparam logic [7:0] PWR_RESET = 8'h00;
	localparam int PWR_LOWP_BIT = 7;
	localparam int PWR_START_BIT = 6;
	localparam int PWR_MASK_MSB = 5;
	localparam int PWR_MASK_LSB = 3;
	localparam int PWR_TRIG0_BIT = 0;
	localparam logic [3:0] SLAVE_ID_DEFAULT = 4'h7;

	// Link clock divider: eight system clocks per link bit
	localparam logic [2:0] PH_SAMPLE = 3'h3;
	localparam logic [2:0] PH_LAST = 3'h7;

	// Master register bus map
	localparam logic [11:0] CTRL_OFF = 12'h000;
	localparam logic [11:0] STAT_OFF = 12'h004;
	localparam int CTRL_OP_LSB = 0;
	localparam int CTRL_SA_LSB = 4;
	localparam int CTRL_ADDR_LSB = 8;
	localparam int CTRL_DATA_LSB = 16;
	localparam int CTRL_GO_BIT = 31;
	localparam logic [1:0] HOP_REG0 = 2'h0;
	localparam logic [1:0] HOP_WRITE = 2'h1;
	localparam logic [1:0] HOP_READ = 2'h2;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_PERR_BIT = 2;
	localparam int STAT_RDATA_LSB = 8;

	// Odd parity bit over up to twelve bits
	function automatic logic odd_par(input logic [11:0] v);
		return ~^v;
	endfunction

endpackage
`default_nettype wire

// file: rfsw_link_if.sv
// rfsw_link_if.sv: two-wire link between the master and the switch slave.
// Assumes the line is parked low whenever neither end drives it.
`timescale 1ns/1ps
`default_nettype none
interface rfsw_link_if;
	logic sclk;
	logic host_sdata_out;
	logic host_sdata_oe;
	logic dev_sdata_out;
	logic dev_sdata_oe;
	logic sdata;

	// Wired line; an undriven line reads as parked low
	assign sdata = (host_sdata_oe & host_sdata_out) |
		(dev_sdata_oe & dev_sdata_out);

	modport host (output sclk, output host_sdata_out,
		output host_sdata_oe, input sdata);
	modport dev (input sclk, input sdata, output dev_sdata_out,
		output dev_sdata_oe);
endinterface
`default_nettype wire

// file: rfsw_sync2.sv
// rfsw_sync2.sv: two flip-flop level synchroniser.
// Assumes din may change at any time relative to clock.
`timescale 1ns/1ps
`default_nettype none
module rfsw_sync2 (
	input wire logic clock,
	input wire logic reset,
	input wire logic din,
	output logic dout
);
	logic meta_reg;

	// First stage feeds only the second
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_reg <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_reg <= din;
			dout <= meta_reg;
		end
	end
endmodule // rfsw_sync2
`default_nettype wire

// file: rfsw_master.sv
// rfsw_master.sv: link master, driven by software over APB.
// Assumes pclk is the system clock; the link clock is divided from it.
`timescale 1ns/1ps
`default_nettype none
module rfsw_master (
	input wire logic clock,
	input wire logic reset,
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	rfsw_link_if.host link
);

	typedef enum logic [7:0] {
		H_IDLE = 8'h01,
		H_SSC = 8'h02,
		H_CMD = 8'h04,
		H_WDATA = 8'h08,
		H_BPC = 8'h10,
		H_TURN = 8'h20,
		H_RX = 8'h40,
		H_RPARK = 8'h80
	} rfsw_host_state_t;

	rfsw_host_state_t state_reg;
	rfsw_host_state_t state_next;
	logic [2:0] ph_reg;
	logic [3:0] cnt_reg;
	logic [3:0] cnt_next;
	logic [21:0] tx_reg;
	logic [21:0] tx_next;
	logic out_reg;
	logic out_next;
	logic oe_reg;
	logic oe_next;
	logic sclk_reg;
	logic [1:0] op_reg;
	logic [23:0] ctrl_reg;
	logic [8:0] rx_reg;
	logic [7:0] rdata_reg;
	logic done_reg;
	logic perr_reg;
	logic sdata_sync;

	// Read-back line comes off another clock, so it is synchronised
	rfsw_sync2 u_sync (
		.clock(clock),
		.reset(reset),
		.din(link.sdata),
		.dout(sdata_sync)
	);

	// Register bus decode; one wait state, effect on the pready edge
	wire logic idle = state_reg == H_IDLE;
	wire logic hit_ctrl = paddr == rfsw_pkg::CTRL_OFF;
	wire logic hit_stat = paddr == rfsw_pkg::STAT_OFF;
	wire logic acc = psel && penable && pready;
	wire logic wr = acc && pwrite;
	wire logic go = wr && hit_ctrl && pwdata[rfsw_pkg::CTRL_GO_BIT] && idle;
	wire logic [31:0] stat_view = {16'h0000, rdata_reg, 5'h00, perr_reg,
		done_reg, !idle};
	wire logic [31:0] rd_mux = hit_ctrl ? {8'h00, ctrl_reg} :
		hit_stat ? stat_view : 32'h0000_0000;

	// Command word built from the control fields
	wire logic [1:0] c_op = pwdata[rfsw_pkg::CTRL_OP_LSB +: 2];
	wire logic [4:0] c_addr = pwdata[rfsw_pkg::CTRL_ADDR_LSB +: 5];
	wire logic [7:0] c_data = pwdata[rfsw_pkg::CTRL_DATA_LSB +: 8];
	wire logic [6:0] c_low = (c_op == rfsw_pkg::HOP_REG0) ? c_data[6:0] :
		{(c_op == rfsw_pkg::HOP_READ) ? rfsw_pkg::OP_READ :
		rfsw_pkg::OP_WRITE, c_addr};
	wire logic [11:0] c_cmd = {pwdata[rfsw_pkg::CTRL_SA_LSB +: 4],
		c_op == rfsw_pkg::HOP_REG0, c_low};
	wire logic [21:0] c_frame = {c_cmd, rfsw_pkg::odd_par(c_cmd), c_data,
		rfsw_pkg::odd_par({4'h0, c_data})};
	wire logic bit_end = !idle && (ph_reg == rfsw_pkg::PH_LAST);
	wire logic frame_end = bit_end &&
		(state_reg == H_BPC || state_reg == H_RPARK);
	wire logic [2:0] ph_next = idle ? rfsw_pkg::PH_LAST : ph_reg + 3'h1;

	// Bit sequencer; each state step lands on a falling link clock edge
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		tx_next = tx_reg;
		out_next = out_reg;
		oe_next = oe_reg;
		if (go) begin
			state_next = H_SSC;
			cnt_next = 4'h0;
			tx_next = c_frame;
			out_next = 1'b1;
			oe_next = 1'b1;
		end else if (bit_end) begin
			cnt_next = cnt_reg + 4'h1;
			unique case (state_reg)
				H_SSC: begin
					out_next = 1'b0;
					if (cnt_reg != 4'h0) begin
						state_next = H_CMD;
						cnt_next = 4'h0;
						out_next = tx_reg[21];
						tx_next = {tx_reg[20:0], 1'b0};
					end
				end
				H_CMD, H_WDATA: begin
					out_next = tx_reg[21];
					tx_next = {tx_reg[20:0], 1'b0};
					if (state_reg == H_CMD && cnt_reg == rfsw_pkg::CMD_LAST) begin
						cnt_next = 4'h0;
						if (op_reg == rfsw_pkg::HOP_WRITE) begin
							state_next = H_WDATA;
						end else if (op_reg == rfsw_pkg::HOP_READ) begin
							state_next = H_TURN;
							out_next = 1'b0;
							oe_next = 1'b0;
						end else begin
							state_next = H_BPC;
							out_next = 1'b0;
						end
					end else if (state_reg == H_WDATA &&
						cnt_reg == rfsw_pkg::DATA_LAST) begin
						state_next = H_BPC;
						out_next = 1'b0;
					end
				end
				H_TURN: begin
					state_next = H_RX;
					cnt_next = 4'h0;
				end
				H_RX: begin
					if (cnt_reg == rfsw_pkg::DATA_LAST) begin
						state_next = H_RPARK;
					end
				end
				default: begin
					state_next = H_IDLE;
					oe_next = 1'b0;
				end
			endcase
		end
	end

	// Link side registers
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state_reg <= H_IDLE;
			ph_reg <= rfsw_pkg::PH_LAST;
			cnt_reg <= 4'h0;
			tx_reg <= 22'h000000;
			out_reg <= 1'b0;
			oe_reg <= 1'b0;
			sclk_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ph_reg <= go ? 3'h0 : ph_next;
			cnt_reg <= cnt_next;
			tx_reg <= tx_next;
			out_reg <= out_next;
			oe_reg <= oe_next;
			sclk_reg <= !go && !idle && ph_next[2];
		end
	end

	// Read capture mid-bit at phase 3, before the link clock rises, after the synchroniser settles
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			rx_reg <= 9'h000;
		end else if (state_reg == H_RX && ph_reg == rfsw_pkg::PH_SAMPLE) begin
			rx_reg <= {rx_reg[7:0], sdata_sync};
		end
	end

	// Software registers; a frame ending beats a done clear
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			op_reg <= rfsw_pkg::HOP_REG0;
			ctrl_reg <= 24'h000000;
			done_reg <= 1'b0;
			perr_reg <= 1'b0;
			rdata_reg <= 8'h00;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && penable && !pready;
			if (psel && penable && !pready) begin
				prdata <= rd_mux;
				pslverr <= !(hit_ctrl || hit_stat);
			end
			if (go) begin
				op_reg <= c_op;
				ctrl_reg <= pwdata[23:0];
				perr_reg <= 1'b0;
			end
			if (frame_end) begin
				done_reg <= 1'b1;
			end else if (wr && hit_stat && pwdata[rfsw_pkg::STAT_DONE_BIT]) begin
				done_reg <= 1'b0;
			end
			if (frame_end && state_reg == H_RPARK) begin
				rdata_reg <= rx_reg[8:1];
				perr_reg <= rx_reg[0] != rfsw_pkg::odd_par({4'h0, rx_reg[8:1]});
			end
		end
	end

	assign link.sclk = sclk_reg;
	assign link.host_sdata_out = out_reg;
	assign link.host_sdata_oe = oe_reg;

endmodule // rfsw_master
`default_nettype wire

// file: rfsw_link_props.sv
// rfsw_link_props.sv: checks on the two-wire link between both ends.
// Assumes the master's system clock and reset; line signals as inputs.
`timescale 1ns/1ps
`default_nettype none
module rfsw_link_props (
	input wire logic clock,
	input wire logic reset,
	input wire logic sclk,
	input wire logic host_sdata_out,
	input wire logic host_sdata_oe,
	input wire logic dev_sdata_out,
	input wire logic dev_sdata_oe,
	input wire logic sdata
);
	logic [7:0] host_cnt_reg;
	logic [7:0] host_cnt_next;
	logic [7:0] dev_cnt_reg;
	logic [7:0] dev_cnt_next;

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// Drive lengths in system clocks; eight clocks make one link bit
	assign host_cnt_next = host_sdata_oe ? host_cnt_reg + 8'h01 : 8'h00;
	assign dev_cnt_next = dev_sdata_oe ? dev_cnt_reg + 8'h01 : 8'h00;

	// Counters restart whenever a driver lets go
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			host_cnt_reg <= 8'h00;
			dev_cnt_reg <= 8'h00;
		end else begin
			host_cnt_reg <= host_cnt_next;
			dev_cnt_reg <= dev_cnt_next;
		end
	end

	start_seq_a: assert property ($rose(host_sdata_oe) |->
		host_sdata_out ##8 !host_sdata_out) else $error("bad start");
	sclk_shape_a: assert property ($rose(sclk) |->
		sclk [*4] ##1 !sclk) else $error("link clock shape");
	data_hold_a: assert property (sclk && $past(sclk) |->
		$stable(host_sdata_out)) else $error("data moved at sample");
	host_len_a: assert property ($fell(host_sdata_oe) |->
		host_cnt_reg inside {8'h78, 8'h80, 8'hc8})
		else $error("host frame length");
	dev_len_a: assert property ($fell(dev_sdata_oe) |->
		dev_cnt_reg == 8'h50) else $error("reply length");
	turn_gap_a: assert property ($rose(dev_sdata_oe) |->
		$past(!host_sdata_oe, 3)) else $error("no turnaround");
	no_clash_a: assert property (!(host_sdata_oe &&
		dev_sdata_oe)) else $error("both drive");
	dev_park_a: assert property ($fell(dev_sdata_oe) |->
		!$past(dev_sdata_out)) else $error("reply not parked");
	host_park_a: assert property ($fell(host_sdata_oe) &&
		host_cnt_reg != 8'h78 |-> !$past(host_sdata_out))
		else $error("host not parked");

	// Main traffic kinds seen on the wire
	cover property ($fell(dev_sdata_oe));
	cover property ($fell(host_sdata_oe) && host_cnt_reg == 8'h80);
	cover property ($fell(host_sdata_oe) && host_cnt_reg == 8'hc8);
endmodule // rfsw_link_props
`default_nettype wire

// file: testbench.sv
// testbench.sv: master and slave joined on one link, plus a second slave
// fed by a bench-made link clock. Assumes the package and interface.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam logic [3:0] SID = 4'h7; // Arbitrary slave address
	logic clock;
	logic reset;
	logic [11:0] paddr;
	logic psel;
	logic penable;
	logic pwrite;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [9:0] throw_on;
	logic [9:0] throw2;
	logic isolated;
	logic isolated2;
	logic low_power;
	logic low_power2;
	int failures;
	int compares;
	logic [4:0] codes [10] = '{5'h02, 5'h0a, 5'h0e, 5'h0b, 5'h01,
		5'h09, 5'h06, 5'h04, 5'h0c, 5'h08};

	rfsw_link_if link ();
	rfsw_link_if link2 ();
	rfsw_master rfsw_master_inst (.clock, .reset, .paddr, .psel,
		.penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.link(link.host));
	rfsw_slave #(.SLAVE_ID(SID)) rfsw_slave_inst (.link(link.dev),
		.reset, .throw_on, .isolated, .low_power);
	// Second slave lets the bench break parity, which the master never does
	rfsw_slave #(.SLAVE_ID(SID)) rfsw_slave_inst2 (.link(link2.dev),
		.reset, .throw_on(throw2), .isolated(isolated2),
		.low_power(low_power2));
	rfsw_link_props rfsw_link_props_inst (.clock, .reset,
		.sclk(link.sclk), .host_sdata_out(link.host_sdata_out),
		.host_sdata_oe(link.host_sdata_oe),
		.dev_sdata_out(link.dev_sdata_out),
		.dev_sdata_oe(link.dev_sdata_oe), .sdata(link.sdata));

	// System clock, 50 ns
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic finish_test();
		if (failures == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_pins(input logic [9:0] t, input logic lp);
		check({20'h0, throw_on, isolated, low_power},
			{20'h0, t, t == 10'h0, lp});
	endtask

	// One APB transfer; waits for pready, taking data at that edge
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clock);
			n++;
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) failures++;
	endtask

	// Start one link operation and poll status until busy drops
	task automatic link_op(input logic [1:0] op, input logic [3:0] sa,
		input logic [4:0] ad, input logic [7:0] d, output logic [31:0] st);
		logic e;
		int n;
		n = 0;
		apb(1'b1, rfsw_pkg::CTRL_OFF,
			{1'b1, 7'h0, d, 3'h0, ad, sa, 2'h0, op}, st, e);
		st = 32'h1;
		while (st[rfsw_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 100) begin
			apb(1'b0, rfsw_pkg::STAT_OFF, 32'h0, st, e);
			n++;
		end
		if (n >= 100) failures++;
	endtask

	// Read over the link; expect {parity error, data}
	task automatic link_rd(input logic [3:0] sa, input logic [4:0] a,
		input logic [8:0] exp);
		logic [31:0] st;
		link_op(rfsw_pkg::HOP_READ, sa, a, 8'h00, st);
		check({23'h0, st[rfsw_pkg::STAT_PERR_BIT], st[15:8]}, {23'h0, exp});
	endtask

	// Full write frame with optional parity faults; odd parity
	function automatic logic [24:0] wr_frame(input logic [7:0] d,
		input logic bc, input logic bd);
		logic [11:0] c;
		c = {SID, 3'b010, rfsw_pkg::ADDR_PWR};
		return {2'b10, c, ~^c ^ bc, d, ~^d ^ bd, 1'b0};
	endfunction

	// Bench-made link clock, 64 ns, running only inside a frame
	task automatic drive_frame(input logic [24:0] b);
		link2.host_sdata_oe = 1'b1;
		for (int i = 24; i >= 0; i--) begin
			link2.host_sdata_out = b[i];
			#32 link2.sclk = 1'b1;
			#32 link2.sclk = 1'b0;
		end
		link2.host_sdata_oe = 1'b0;
		link2.host_sdata_out = ~b[0];
	endtask

	// Watchdog well beyond the expected run
	initial begin
		#3000000;
		failures++;
		finish_test();
	end

	initial begin
		logic [31:0] st;
		logic [31:0] r;
		logic e;
		failures = 0;
		compares = 0;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		link2.sclk = 1'b0;
		link2.host_sdata_out = 1'b0;
		link2.host_sdata_oe = 1'b0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		check_pins(10'h0, 1'b0);
		link_rd(SID, rfsw_pkg::ADDR_PATH, 9'h000);
		link_rd(SID, rfsw_pkg::ADDR_PWR, 9'h000);
		// Masks clear: compact write waits in the shadow for trigger 0
		link_op(rfsw_pkg::HOP_REG0, SID, 5'h00, 8'h0a, st);
		check_pins(10'h0, 1'b0);
		link_rd(SID, rfsw_pkg::ADDR_PATH, 9'h000);
		link_op(rfsw_pkg::HOP_WRITE, SID, rfsw_pkg::ADDR_PWR, 8'h01, st);
		check_pins(10'h002, 1'b0);
		link_op(rfsw_pkg::HOP_WRITE, SID, rfsw_pkg::ADDR_PWR, 8'h08, st);
		link_rd(SID, rfsw_pkg::ADDR_PWR, 9'h008);
		// Every throw, with ignored upper bits 6 and 5 set
		for (int i = 0; i < 10; i++) begin
			link_op(rfsw_pkg::HOP_REG0, SID, 5'h00, {3'b011, codes[i]}, st);
			check_pins(10'h1 << i, 1'b0);
		end
		link_rd(SID, rfsw_pkg::ADDR_PATH, 9'h068);
		link_op(rfsw_pkg::HOP_WRITE, SID, rfsw_pkg::ADDR_PATH, 8'h8c, st);
		check_pins(10'h100, 1'b0);
		link_rd(SID, rfsw_pkg::ADDR_PATH, 9'h08c);
		link_op(rfsw_pkg::HOP_WRITE, SID, rfsw_pkg::ADDR_PATH, 8'h12, st);
		check_pins(10'h0, 1'b0);
		link_op(rfsw_pkg::HOP_REG0, 4'h3, 5'h00, 8'h02, st);
		check_pins(10'h0, 1'b0);
		link_rd(4'h3, rfsw_pkg::ADDR_PATH, 9'h100);
		link_op(rfsw_pkg::HOP_WRITE, SID, rfsw_pkg::ADDR_PWR, 8'h88, st);
		check_pins(10'h0, 1'b1);
		link_rd(SID, rfsw_pkg::ADDR_PWR, 9'h088);
		link_op(rfsw_pkg::HOP_REG0, SID, 5'h00, 8'h02, st);
		link_op(rfsw_pkg::HOP_WRITE, SID, rfsw_pkg::ADDR_PWR, 8'h40, st);
		check_pins(10'h0, 1'b0);
		link_rd(SID, rfsw_pkg::ADDR_PWR, 9'h000);
		// Control reads back its fields; done stays until cleared
		apb(1'b0, rfsw_pkg::CTRL_OFF, 32'h0, r, e);
		check({r[30:0], e}, {7'h0, 8'h00, 3'h0, rfsw_pkg::ADDR_PWR, SID,
			2'h0, rfsw_pkg::HOP_READ, 1'b0});
		apb(1'b0, rfsw_pkg::STAT_OFF, 32'h0, r, e);
		check({r[30:0], e}, 32'h0000_0004);
		apb(1'b1, rfsw_pkg::STAT_OFF, 32'h0000_0002, r, e);
		apb(1'b0, rfsw_pkg::STAT_OFF, 32'h0, r, e);
		check({r[30:0], e}, 32'h0000_0000);
		// Unmapped register: error and zero data
		apb(1'b0, 12'h008, 32'h0, r, e);
		check({r[30:0], e}, 32'h1);
		// Parity faults on the second link must leave it untouched
		drive_frame(wr_frame(8'h80, 1'b1, 1'b0));
		check({31'h0, low_power2}, 32'h0);
		drive_frame(wr_frame(8'h80, 1'b0, 1'b1));
		check({31'h0, low_power2}, 32'h0);
		drive_frame(wr_frame(8'h80, 1'b0, 1'b0));
		check({21'h0, throw2, low_power2}, 32'h1);
		finish_test();
	end
endmodule // testbench
`default_nettype wire
